// ===== verilog/bw_monitor_pkg.sv
// constants shared by the bandwidth usage monitor bank
// assumes a single clock domain and plain-port configuration
package bw_monitor_pkg;
  localparam int unsigned max_monitors = 65536;
  localparam int unsigned count_width = 32;
  localparam int unsigned partition_id_width = 16;
  localparam int unsigned group_width = 8;
  localparam int unsigned bytes_width = 8;
  localparam int unsigned trig_sel_width = 3;
  localparam int unsigned ext_events = 7;
  localparam logic [2:0] trig_sel_local = 3'h7;
  localparam logic reset_flag = 1'b0;
  localparam logic [31:0] reset_count = 32'h0;
endpackage

// ===== verilog/bw_monitor_unit.sv
// one bandwidth usage monitor: filter, live count, snapshot, flags
// assumes configuration is held stable by the parent's ports
module bw_monitor_unit #(
  parameter int unsigned cw = bw_monitor_pkg::count_width,
  parameter int unsigned pw = bw_monitor_pkg::partition_id_width,
  parameter int unsigned gw = bw_monitor_pkg::group_width,
  parameter int unsigned bw = bw_monitor_pkg::bytes_width
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic xfer_valid,
  input wire logic xfer_write,
  input wire logic [pw-1:0] xfer_partition_id,
  input wire logic [gw-1:0] xfer_monitoring_group,
  input wire logic [bw-1:0] xfer_bytes,
  input wire logic flt_count_reads,
  input wire logic flt_count_writes,
  input wire logic [pw-1:0] flt_partition_id,
  input wire logic [gw-1:0] flt_monitoring_group,
  input wire logic filter_write,
  input wire logic capture,
  input wire logic clear_on_snapshot,
  input wire logic wrap_clear,
  input wire logic nsf_write,
  input wire logic nsf_wdata,
  output logic [cw-1:0] count,
  output logic not_settled_flag,
  output logic [cw-1:0] snap_count,
  output logic snap_not_settled,
  output logic wrap_flag
);
  typedef struct packed {
    logic [cw-1:0] cnt;
    logic nsf;
    logic [cw-1:0] snap;
    logic snap_nsf;
    logic wrap;
  } unit_state_t;

  unit_state_t s_q;
  unit_state_t s_d;
  logic hit;
  logic [cw:0] sum;

  always_comb begin
    s_d = s_q;
    hit = xfer_valid && (xfer_write ? flt_count_writes : flt_count_reads)
      && xfer_partition_id == flt_partition_id && xfer_monitoring_group == flt_monitoring_group;
    sum = {1'b0, s_q.cnt} + (hit ? {{(cw+1-bw){1'b0}}, xfer_bytes} : {(cw+1){1'b0}});
    if (nsf_write) begin
      s_d.nsf = nsf_wdata;
    end
    if (capture) begin
      s_d.snap = s_q.cnt;
      s_d.snap_nsf = s_q.nsf;
      s_d.nsf = 1'b0;
    end
    // bytes of a transfer landing in the capture cycle go into the new interval
    if (capture && clear_on_snapshot) begin
      s_d.cnt = hit ? {{(cw-bw){1'b0}}, xfer_bytes} : '0;
    end else begin
      s_d.cnt = sum[cw-1:0];
    end
    if (wrap_clear) begin
      s_d.wrap = 1'b0;
    end
    if (!(capture && clear_on_snapshot) && sum[cw]) begin
      s_d.wrap = 1'b1; // set wins over clear
    end
    if (filter_write) begin
      s_d.nsf = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{cnt: '0, nsf: 1'b0, snap: '0, snap_nsf: 1'b0, wrap: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign not_settled_flag = s_q.nsf;
  assign snap_count = s_q.snap;
  assign snap_not_settled = s_q.snap_nsf;
  assign wrap_flag = s_q.wrap;
endmodule // bw_monitor_unit

// ===== verilog/bandwidth_usage_monitor.sv
// bank of bandwidth usage monitors with capture-event selection
// assumes transfers and configuration ports are synchronous to mclk
// What this block does
// - component holds any number of monitors, at most 2^16
// - each monitor watches one partition and monitoring group pair
// - filter config picks reads, writes, partition and group
// - live count adds bytes of matching downstream transfers
// - capture event copies live count into the snapshot
// - writing the filter sets the not-settled flag
// - capture clears the live not-settled flag, unless the filter is written in the same cycle
// - snapshot takes the not-settled flag from before its clearing
// - capture may optionally also clear the live count
// - with clearing, snapshot holds one interval, live count the current one
// - trigger select field chooses which event source captures
// - local generator exists only when local_trigger_present is 1
// - writing local trigger with now bit set raises a local event
// - without local generator, select 7 never captures
// - clear-on-snapshot restarts count from bytes matching in the capture cycle, else zero
// - counter overflow sets wrap flag until software writes 0
module bandwidth_usage_monitor #(
  parameter int unsigned num_monitors = 4,
  parameter logic local_trigger_present = 1'b1,
  parameter int unsigned cw = bw_monitor_pkg::count_width
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic xfer_valid,
  input wire logic xfer_write,
  input wire logic [bw_monitor_pkg::partition_id_width-1:0] xfer_partition_id,
  input wire logic [bw_monitor_pkg::group_width-1:0] xfer_monitoring_group,
  input wire logic [bw_monitor_pkg::bytes_width-1:0] xfer_bytes,
  input wire logic [bw_monitor_pkg::ext_events-1:0] ext_trigger,
  input wire logic local_trigger_write,
  input wire logic trigger_now_bit,
  input wire logic [num_monitors-1:0] flt_count_reads,
  input wire logic [num_monitors-1:0] flt_count_writes,
  input wire logic [num_monitors*bw_monitor_pkg::partition_id_width-1:0] flt_partition_id,
  input wire logic [num_monitors*bw_monitor_pkg::group_width-1:0] flt_monitoring_group,
  input wire logic [num_monitors-1:0] filter_write,
  input wire logic [num_monitors*bw_monitor_pkg::trig_sel_width-1:0] snapshot_trigger_select,
  input wire logic [num_monitors-1:0] clear_on_snapshot,
  input wire logic [num_monitors-1:0] wrap_clear,
  input wire logic [num_monitors-1:0] nsf_write,
  input wire logic [num_monitors-1:0] nsf_wdata,
  output logic local_trigger_present_o,
  output logic [num_monitors*cw-1:0] bandwidth_count,
  output logic [num_monitors-1:0] not_settled_flag,
  output logic [num_monitors*cw-1:0] bandwidth_count_snapshot,
  output logic [num_monitors-1:0] snap_not_settled,
  output logic [num_monitors-1:0] wrap_flag
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic local_evt;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic rst_n;
  logic [num_monitors-1:0] capture;

  // selects 0..6 map to external lines, 7 to the local generator
  function automatic logic pick_event(input logic [2:0] sel, input logic [6:0] ext, input logic loc);
    pick_event = (sel == bw_monitor_pkg::trig_sel_local) ? loc : ext[sel];
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{rst_sync: 2'h0, local_evt: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
    s_d.local_evt = local_trigger_present && local_trigger_write && trigger_now_bit;
  end

  assign rst_n = s_q.rst_sync[1];
  assign local_trigger_present_o = local_trigger_present;

  // num_monitors must not exceed bw_monitor_pkg::max_monitors; the integrator keeps to it

  for (genvar i = 0; i < num_monitors; i++) begin : g_mon
    assign capture[i] = pick_event(snapshot_trigger_select[i*3 +: 3], ext_trigger, s_q.local_evt);
    bw_monitor_unit #(.cw(cw)) u_unit (
      .mclk(mclk),
      .rst_n(rst_n),
      .xfer_valid(xfer_valid),
      .xfer_write(xfer_write),
      .xfer_partition_id(xfer_partition_id),
      .xfer_monitoring_group(xfer_monitoring_group),
      .xfer_bytes(xfer_bytes),
      .flt_count_reads(flt_count_reads[i]),
      .flt_count_writes(flt_count_writes[i]),
      .flt_partition_id(flt_partition_id[i*bw_monitor_pkg::partition_id_width +: bw_monitor_pkg::partition_id_width]),
      .flt_monitoring_group(flt_monitoring_group[i*bw_monitor_pkg::group_width +: bw_monitor_pkg::group_width]),
      .filter_write(filter_write[i]),
      .capture(capture[i]),
      .clear_on_snapshot(clear_on_snapshot[i]),
      .wrap_clear(wrap_clear[i]),
      .nsf_write(nsf_write[i]),
      .nsf_wdata(nsf_wdata[i]),
      .count(bandwidth_count[i*cw +: cw]),
      .not_settled_flag(not_settled_flag[i]),
      .snap_count(bandwidth_count_snapshot[i*cw +: cw]),
      .snap_not_settled(snap_not_settled[i]),
      .wrap_flag(wrap_flag[i])
    );
  end
endmodule // bandwidth_usage_monitor

// ===== sim/bum_sva.sv
// assertions on the monitor bank ports, monitor 0 only
// bound into every bandwidth_usage_monitor instance
module bum_sva #(
  parameter int unsigned num_monitors = 4,
  parameter int unsigned cw = 32
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic xfer_valid,
  input wire logic xfer_write,
  input wire logic [15:0] xfer_partition_id,
  input wire logic [7:0] xfer_monitoring_group,
  input wire logic [7:0] xfer_bytes,
  input wire logic [6:0] ext_trigger,
  input wire logic local_trigger_write,
  input wire logic trigger_now_bit,
  input wire logic [num_monitors-1:0] flt_count_reads,
  input wire logic [num_monitors-1:0] flt_count_writes,
  input wire logic [num_monitors*16-1:0] flt_partition_id,
  input wire logic [num_monitors*8-1:0] flt_monitoring_group,
  input wire logic [num_monitors-1:0] filter_write,
  input wire logic [num_monitors*3-1:0] snapshot_trigger_select,
  input wire logic [num_monitors-1:0] clear_on_snapshot,
  input wire logic [num_monitors-1:0] wrap_clear,
  input wire logic [num_monitors-1:0] nsf_write,
  input wire logic local_trigger_present_o,
  input wire logic [num_monitors*cw-1:0] bandwidth_count,
  input wire logic [num_monitors-1:0] not_settled_flag,
  input wire logic [num_monitors*cw-1:0] bandwidth_count_snapshot,
  input wire logic [num_monitors-1:0] snap_not_settled,
  input wire logic [num_monitors-1:0] wrap_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic [2:0] sel = snapshot_trigger_select[2:0];
  // select 7 is the local source, so it never indexes the external lines
  wire logic cap = sel != 3'h7 && ext_trigger[sel];
  wire logic m = xfer_valid && (xfer_write ? flt_count_writes[0] : flt_count_reads[0])
    && xfer_partition_id == flt_partition_id[15:0] && xfer_monitoring_group == flt_monitoring_group[7:0];
  wire logic [cw-1:0] cnt = bandwidth_count[cw-1:0];
  wire logic [cw-1:0] snap = bandwidth_count_snapshot[cw-1:0];
  a_flag_on_filter: assert property (filter_write[0] |=> not_settled_flag[0]) else $error("flag unset");
  a_snap_count: assert property (cap |=> snap == $past(cnt)) else $error("snapshot count");
  a_snap_flag: assert property (cap |=> snap_not_settled[0] == $past(not_settled_flag[0])) else $error("snap flag");
  a_flag_cleared: assert property (cap && !filter_write[0] && !nsf_write[0] |=> !not_settled_flag[0]) else $error("flag");
  a_clear_capture: assert property (cap && clear_on_snapshot[0]
    |=> cnt == ($past(m) ? cw'($past(xfer_bytes)) : '0)) else $error("clear on capture");
  a_count_add: assert property (m && !clear_on_snapshot[0]
    |=> cnt == $past(cnt) + cw'($past(xfer_bytes))) else $error("count add");
  a_local_snap: assert property (local_trigger_write && trigger_now_bit && local_trigger_present_o
    && sel == 3'h7 |=> ##1 snap == $past(cnt)) else $error("local capture");
  a_wrap_sticky: assert property (wrap_flag[0] && !wrap_clear[0] |=> wrap_flag[0]) else $error("wrap dropped");
endmodule // bum_sva
bind bandwidth_usage_monitor bum_sva #(.num_monitors(num_monitors), .cw(cw)) bum_sva_i (.*);

// ===== sim/xfer_source.sv
// interconnect model: one downstream transfer per put call
// put is called shortly after a rising edge of mclk
module xfer_source (
  input wire logic mclk,
  output logic xfer_valid = 1'h0,
  output logic xfer_write = 1'h1,
  output logic [15:0] xfer_partition_id = 16'hffff,
  output logic [7:0] xfer_monitoring_group = 8'hff,
  output logic [7:0] xfer_bytes = 8'hff
);
  timeunit 1ns;
  timeprecision 100ps;
  // every monitor of the bank sees the same downstream stream; totals over components are summed by software
  task automatic put(input logic w, input logic [15:0] p, input logic [7:0] g, input logic [7:0] b);
    {xfer_valid, xfer_write, xfer_partition_id, xfer_monitoring_group, xfer_bytes} = {1'h1, w, p, g, b};
    @(posedge mclk);
    #1;
    // tags are not held past the sample edge, so show their inverse
    {xfer_valid, xfer_write, xfer_partition_id, xfer_monitoring_group, xfer_bytes} = {1'h0, ~w, ~p, ~g, ~b};
  endtask
endmodule // xfer_source

// ===== sim/tb_top.sv
// self-checking bench: one monitor, 8-bit count so overflow is quick
// assumes the design package and checker are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic [6:0] ext_trigger = 7'h0;
  logic local_trigger_write = 1'h0, trigger_now_bit = 1'h0, filter_write = 1'h0, wrap_clear = 1'h0;
  logic flt_count_reads = 1'h1, flt_count_writes = 1'h0, clear_on_snapshot = 1'h0, nsf_write = 1'h0, nsf_wdata = 1'h0;
  logic [15:0] flt_partition_id = 16'h0005;
  logic [7:0] flt_monitoring_group = 8'h03;
  logic [2:0] snapshot_trigger_select = 3'h2;
  wire logic xfer_valid, xfer_write, local_trigger_present_o, not_settled_flag, snap_not_settled, wrap_flag;
  wire logic [15:0] xfer_partition_id;
  wire logic [7:0] xfer_monitoring_group, xfer_bytes, bandwidth_count, bandwidth_count_snapshot;
  int fails = 0, samples_checked = 0, cycles = 0;
  bandwidth_usage_monitor #(.num_monitors(1), .cw(8)) bandwidth_usage_monitor_i (.*);
  xfer_source xfer_source_i (.*);
  always #5 mclk = ~mclk;
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 500) begin
      fails++;
      results();
    end
  end
  initial begin
    step(5);
    resetn = 1'h1;
    step(4);
    // only the first transfer is a read of the watched pair
    for (int i = 0; i < 4; i++) begin
      xfer_source_i.put(i == 1, i == 2 ? 16'h0006 : 16'h0005, i == 3 ? 8'h02 : 8'h03, 8'h04 << i);
      step(1);
    end
    check(bandwidth_count, 32'h4);
    check(local_trigger_present_o, 32'h1);
    filter_write = 1'h1;
    step(1);
    filter_write = 1'h0;
    check(not_settled_flag, 32'h1);
    clear_on_snapshot = 1'h1;
    ext_trigger = 7'h02;
    step(1);
    ext_trigger = 7'h04; // one shared event line
    fork
      xfer_source_i.put(1'h0, 16'h0005, 8'h03, 8'h03);
      step(1);
    join
    ext_trigger = 7'h00;
    check(bandwidth_count_snapshot, 32'h4);
    check(snap_not_settled, 32'h1);
    check(not_settled_flag, 32'h0);
    check(bandwidth_count, 32'h3);
    snapshot_trigger_select = 3'h7;
    local_trigger_write = 1'h1;
    step(1);
    trigger_now_bit = 1'h1;
    step(1);
    local_trigger_write = 1'h0;
    trigger_now_bit = 1'h0;
    step(2);
    check(bandwidth_count_snapshot, 32'h3);
    check(bandwidth_count, 32'h0);
    clear_on_snapshot = 1'h0;
    flt_count_writes = 1'h1;
    repeat (2) begin
      xfer_source_i.put(1'h1, 16'h0005, 8'h03, 8'hff);
      step(1);
    end
    check(bandwidth_count, 32'hfe);
    check(wrap_flag, 32'h1);
    check(bandwidth_count_snapshot, 32'h3);
    wrap_clear = 1'h1;
    step(1);
    wrap_clear = 1'h0;
    check(wrap_flag, 32'h0);
    // software sets the live flag, then a local capture without clearing
    nsf_write = 1'h1;
    nsf_wdata = 1'h1;
    step(1);
    nsf_write = 1'h0;
    check(not_settled_flag, 32'h1);
    local_trigger_write = 1'h1;
    trigger_now_bit = 1'h1;
    step(1);
    local_trigger_write = 1'h0;
    trigger_now_bit = 1'h0;
    step(1);
    check(snap_not_settled, 32'h1);
    check(not_settled_flag, 32'h0);
    check(bandwidth_count_snapshot, 32'hfe);
    check(bandwidth_count, 32'hfe);
    results();
  end
endmodule // tb_top
